/* mpg_gpio_bank.v */
// Three 8-bit GPIO ports with peripheral override and parallel slave data mode.
//
// The address-and-strobe port was left to the implementer.
`include "mpg_map.vh"
`default_nettype none

module mpg_gpio_bank (
  input wire ref_clk_i,
  input wire rst_i,
  // Register port.
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Second port pins.
  input wire [7:0] port_b_in_i,
  output reg [7:0] port_b_out_o,
  output reg [7:0] port_b_oe_o,
  output reg [7:0] port_b_pullup_o,
  // Third port pins.
  input wire [7:0] port_c_in_i,
  output reg [7:0] port_c_out_o,
  output reg [7:0] port_c_oe_o,
  // Fourth port pins.
  input wire [7:0] port_d_in_i,
  output reg [7:0] port_d_out_o,
  output reg [7:0] port_d_oe_o,
  // Third-port peripherals: enable and output value of each, and output enable of all but the oscillator.
  input wire sec_osc_en_i,
  input wire sec_osc_out_i,
  input wire ccp_two_en_i,
  input wire ccp_two_out_i,
  input wire ccp_two_oe_i,
  input wire ccp_one_en_i,
  input wire ccp_one_out_i,
  input wire ccp_one_oe_i,
  input wire ssp_en_i,
  input wire [2:0] ssp_out_i,
  input wire [2:0] ssp_oe_i,
  input wire usart_en_i,
  input wire [1:0] usart_out_i,
  input wire [1:0] usart_oe_i,
  output reg [7:0] port_c_periph_in_o,
  // Host parallel port data path and status from the slave port logic.
  input wire host_parallel_port_drive_i,
  input wire [7:0] host_parallel_port_wdata_i,
  input wire input_buffer_full_i,
  input wire output_buffer_full_i,
  input wire input_overflow_set_i,
  output reg [7:0] host_parallel_port_rdata_o,
  output reg parallel_slave_enable_o,
  output reg [2:0] port_e_dir_o,
  output reg [7:0] timer_pullup_options_o
);

  // Two-stage synchronisers for all 24 incoming pins: {d, c, b}.
  reg [23:0] pin_meta_q;
  reg [23:0] pin_sync_q;
  wire [23:0] pin_raw;
  assign pin_raw = {port_d_in_i, port_c_in_i, port_b_in_i};

  // Output data latches; deliberately never reset so they survive warm resets.
  reg [7:0] port_b_latch_q;
  reg [7:0] port_c_latch_q;
  reg [7:0] port_d_latch_q;

  // Direction, option and port-E control registers.
  reg [7:0] port_b_direction_q;
  reg [7:0] port_c_direction_q;
  reg [7:0] port_d_direction_q;
  reg [7:0] options_q;
  reg [2:0] port_e_dir_q;
  reg parallel_slave_enable_q;
  reg input_overflow_q;

  // Combinational third-port peripheral routing.
  reg [7:0] periph_sel;
  reg [7:0] periph_out;
  reg [7:0] periph_oe;

  // Next values of the registered pin outputs and of the read data.
  reg [7:0] port_c_out_d;
  reg [7:0] port_c_oe_d;
  reg [7:0] port_d_out_d;
  reg [7:0] port_d_oe_d;
  reg [7:0] rdata_d;

  // Write decode strobes.
  wire wr_b;
  wire wr_c;
  wire wr_d;
  wire wr_opt;
  wire wr_bdir;
  wire wr_cdir;
  wire wr_ddir;
  wire wr_e;
  assign wr_b = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_B_PINS);
  assign wr_c = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_C_PINS);
  assign wr_d = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_D_PINS);
  assign wr_opt = reg_wr_i && (reg_addr_i == `MPG_ADDR_TIMER_PULLUP_OPTIONS);
  assign wr_bdir = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_B_DIRECTION);
  assign wr_cdir = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_C_DIRECTION);
  assign wr_ddir = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_D_DIRECTION);
  assign wr_e = reg_wr_i && (reg_addr_i == `MPG_ADDR_PORT_E_DIR_SLAVE_CTRL);

  // Each pin bit gets its own two-flop synchroniser; only stage two is read.
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_sync
      always @(posedge ref_clk_i) begin
        pin_meta_q[gi] <= pin_raw[gi];
        pin_sync_q[gi] <= pin_meta_q[gi];
      end
    end
  endgenerate

  // Data latches follow writes whatever the direction, and ignore reset.
  always @(posedge ref_clk_i) begin
    if (wr_b) begin
      port_b_latch_q <= reg_wdata_i;
    end
    if (wr_c) begin
      port_c_latch_q <= reg_wdata_i;
    end
    if (wr_d) begin
      port_d_latch_q <= reg_wdata_i;
    end
  end

  // Control registers; every reset type loads the same values here.
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      port_b_direction_q <= `MPG_RST_DIRECTION;
      port_c_direction_q <= `MPG_RST_DIRECTION;
      port_d_direction_q <= `MPG_RST_DIRECTION;
      options_q <= `MPG_RST_OPTIONS;
      port_e_dir_q <= `MPG_RST_PORT_E_DIR;
      parallel_slave_enable_q <= 1'b0;
      input_overflow_q <= 1'b0;
    end else begin
      if (wr_bdir) begin
        port_b_direction_q <= reg_wdata_i;
      end
      if (wr_cdir) begin
        // The stored bits stay as written; peripheral overrides act downstream only.
        port_c_direction_q <= reg_wdata_i;
      end
      if (wr_ddir) begin
        port_d_direction_q <= reg_wdata_i;
      end
      if (wr_opt) begin
        options_q <= reg_wdata_i;
      end
      if (wr_e) begin
        port_e_dir_q <= reg_wdata_i[`MPG_E_DIR_HI:`MPG_E_DIR_LO];
        parallel_slave_enable_q <= reg_wdata_i[`MPG_E_PARALLEL_SLAVE_ENABLE];
      end
      // Overflow is cleared by reset or by software; a new overflow wins over the clear.
      if (input_overflow_set_i) begin
        input_overflow_q <= 1'b1;
      end else if (wr_e) begin
        input_overflow_q <= reg_wdata_i[`MPG_E_INPUT_OVERFLOW];
      end
    end
  end

  // Gather the shared peripherals onto their third-port pin positions.
  always @* begin
    periph_sel = `MPG_ZERO_BYTE;
    periph_out = `MPG_ZERO_BYTE;
    periph_oe = `MPG_ZERO_BYTE;
    // Oscillator drives bit 0 and forces bit 1 to input.
    if (sec_osc_en_i) begin
      periph_sel[`MPG_C_SEC_OSC_OUT] = 1'b1;
      periph_out[`MPG_C_SEC_OSC_OUT] = sec_osc_out_i;
      periph_oe[`MPG_C_SEC_OSC_OUT] = 1'b1;
      periph_sel[`MPG_C_SEC_OSC_IN] = 1'b1;
    end else if (ccp_two_en_i) begin
      // The oscillator owns bit 1 when both are enabled, since a crystal cannot share.
      periph_sel[`MPG_C_CCP_TWO] = 1'b1;
      periph_out[`MPG_C_CCP_TWO] = ccp_two_out_i;
      periph_oe[`MPG_C_CCP_TWO] = ccp_two_oe_i;
    end
    if (ccp_one_en_i) begin
      periph_sel[`MPG_C_CCP_ONE] = 1'b1;
      periph_out[`MPG_C_CCP_ONE] = ccp_one_out_i;
      periph_oe[`MPG_C_CCP_ONE] = ccp_one_oe_i;
    end
    // Serial clock on bit 3, data in or I2C data on bit 4, data out on bit 5.
    if (ssp_en_i) begin
      periph_sel[`MPG_C_SSP_HI:`MPG_C_SSP_LO] = 3'h7;
      periph_out[`MPG_C_SSP_HI:`MPG_C_SSP_LO] = ssp_out_i;
      periph_oe[`MPG_C_SSP_HI:`MPG_C_SSP_LO] = ssp_oe_i;
    end
    // Transmit or clock on bit 6, receive or data on bit 7.
    if (usart_en_i) begin
      periph_sel[`MPG_C_USART_HI:`MPG_C_USART_LO] = 2'h3;
      periph_out[`MPG_C_USART_HI:`MPG_C_USART_LO] = usart_out_i;
      periph_oe[`MPG_C_USART_HI:`MPG_C_USART_LO] = usart_oe_i;
    end
  end

  // Third-port output mux and driver enable, per pin.
  always @* begin
    port_c_out_d = (periph_sel & periph_out) | (~periph_sel & port_c_latch_q);
    // Peripheral enable counts only where selected; elsewhere the direction bit rules.
    port_c_oe_d = (periph_sel & periph_oe) | (~periph_sel & ~port_c_direction_q);
  end

  // Fourth port: ordinary I/O, or the host bus data lanes in slave mode.
  always @* begin
    if (parallel_slave_enable_q) begin
      port_d_out_d = host_parallel_port_wdata_i;
      port_d_oe_d = {8{host_parallel_port_drive_i}};
    end else begin
      port_d_out_d = port_d_latch_q;
      port_d_oe_d = ~port_d_direction_q;
    end
  end

  // Read mux: data registers show synchronised pin levels, not the latches.
  always @* begin
    rdata_d = `MPG_ZERO_BYTE;
    case (reg_addr_i)
      `MPG_ADDR_PORT_B_PINS: begin
        rdata_d = pin_sync_q[7:0];
      end
      `MPG_ADDR_PORT_C_PINS: begin
        rdata_d = pin_sync_q[15:8];
      end
      `MPG_ADDR_PORT_D_PINS: begin
        rdata_d = pin_sync_q[23:16];
      end
      `MPG_ADDR_TIMER_PULLUP_OPTIONS: begin
        rdata_d = options_q;
      end
      `MPG_ADDR_PORT_B_DIRECTION: begin
        rdata_d = port_b_direction_q;
      end
      `MPG_ADDR_PORT_C_DIRECTION: begin
        rdata_d = port_c_direction_q;
      end
      `MPG_ADDR_PORT_D_DIRECTION: begin
        rdata_d = port_d_direction_q;
      end
      `MPG_ADDR_PORT_E_DIR_SLAVE_CTRL: begin
        // Bit 3 is unimplemented and reads zero from the default above.
        rdata_d[`MPG_E_INPUT_BUFFER_FULL] = input_buffer_full_i;
        rdata_d[`MPG_E_OUTPUT_BUFFER_FULL] = output_buffer_full_i;
        rdata_d[`MPG_E_INPUT_OVERFLOW] = input_overflow_q;
        rdata_d[`MPG_E_PARALLEL_SLAVE_ENABLE] = parallel_slave_enable_q;
        rdata_d[`MPG_E_DIR_HI:`MPG_E_DIR_LO] = port_e_dir_q;
      end
      default: begin
        rdata_d = `MPG_ZERO_BYTE;
      end
    endcase
  end

  // Output registers; pin drivers lag their cause by one cycle for clean timing.
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `MPG_ZERO_BYTE;
      port_b_oe_o <= `MPG_ZERO_BYTE;
      port_c_oe_o <= `MPG_ZERO_BYTE;
      port_d_oe_o <= `MPG_ZERO_BYTE;
      port_b_pullup_o <= `MPG_ZERO_BYTE;
      parallel_slave_enable_o <= 1'b0;
      port_e_dir_o <= `MPG_RST_PORT_E_DIR;
      timer_pullup_options_o <= `MPG_RST_OPTIONS;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end else begin
        reg_rdata_o <= `MPG_ZERO_BYTE;
      end
      port_b_oe_o <= ~port_b_direction_q;
      port_c_oe_o <= port_c_oe_d;
      port_d_oe_o <= port_d_oe_d;
      // Pull-ups only on input pins, and only while the disable bit is clear.
      port_b_pullup_o <= port_b_direction_q & {8{~options_q[`MPG_OPT_PULLUP_DISABLE]}};
      parallel_slave_enable_o <= parallel_slave_enable_q;
      port_e_dir_o <= port_e_dir_q;
      timer_pullup_options_o <= options_q;
    end
  end

  // Data outputs carry the unreset latches on pins no peripheral or slave mode owns, so those hold across warm resets.
  always @(posedge ref_clk_i) begin
    port_b_out_o <= port_b_latch_q;
    port_c_out_o <= port_c_out_d;
    port_d_out_o <= port_d_out_d;
    port_c_periph_in_o <= pin_sync_q[15:8];
    host_parallel_port_rdata_o <= pin_sync_q[23:16];
  end

endmodule

`default_nettype wire

/* mpg_map.vh */
// Register map, field positions and reset values of the multi-port GPIO bank.
`ifndef MPG_MAP_VH
`define MPG_MAP_VH
// Register addresses on the 8-bit register port.
`define MPG_ADDR_PORT_B_PINS 8'h06
`define MPG_ADDR_PORT_C_PINS 8'h07
`define MPG_ADDR_PORT_D_PINS 8'h08
`define MPG_ADDR_TIMER_PULLUP_OPTIONS 8'h81
`define MPG_ADDR_PORT_B_DIRECTION 8'h86
`define MPG_ADDR_PORT_C_DIRECTION 8'h87
`define MPG_ADDR_PORT_D_DIRECTION 8'h88
`define MPG_ADDR_PORT_E_DIR_SLAVE_CTRL 8'h89
// Reset values.
`define MPG_RST_OPTIONS 8'hff
`define MPG_RST_DIRECTION 8'hff
`define MPG_RST_PORT_E_DIR 3'h7
`define MPG_ZERO_BYTE 8'h00
// Fields of the port-E direction and slave control register.
`define MPG_E_INPUT_BUFFER_FULL 7
`define MPG_E_OUTPUT_BUFFER_FULL 6
`define MPG_E_INPUT_OVERFLOW 5
`define MPG_E_PARALLEL_SLAVE_ENABLE 4
`define MPG_E_DIR_HI 2
`define MPG_E_DIR_LO 0
// Pull-up disable bit in the option register.
`define MPG_OPT_PULLUP_DISABLE 7
// Third-port pin positions of the shared peripheral functions.
`define MPG_C_SEC_OSC_OUT 0
`define MPG_C_SEC_OSC_IN 1
`define MPG_C_CCP_TWO 1
`define MPG_C_CCP_ONE 2
`define MPG_C_SSP_LO 3
`define MPG_C_SSP_HI 5
`define MPG_C_USART_LO 6
`define MPG_C_USART_HI 7
`endif

/* mpg_gpio_checker.sv */
// Checker of register timing, pin override and slave-mode drive of the GPIO bank.
`default_nettype none
module mpg_gpio_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] port_b_oe_o,
  input wire logic [7:0] port_b_pullup_o,
  input wire logic [7:0] port_c_oe_o,
  input wire logic [7:0] port_d_in_i,
  input wire logic [7:0] port_d_out_o,
  input wire logic [7:0] port_d_oe_o,
  input wire logic ssp_en_i,
  input wire logic [2:0] ssp_oe_i,
  input wire logic host_parallel_port_drive_i,
  input wire logic [7:0] host_parallel_port_wdata_i,
  input wire logic [7:0] host_parallel_port_rdata_o,
  input wire logic parallel_slave_enable_o,
  input wire logic [2:0] port_e_dir_o
);
  // Reset history, so the pin pipe is judged only once it holds post-reset samples.
  logic [2:0] rst_hist_q;
  always_ff @(posedge ref_clk_i) rst_hist_q <= {rst_hist_q[1:0], rst_i};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_slot: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
    else $error("read data outside its slot");
  a_reset_state: assert property ($fell(rst_i) |-> port_b_oe_o == 8'h00 && port_c_oe_o == 8'h00
    && port_d_oe_o == 8'h00 && port_e_dir_o == 3'h7 && !parallel_slave_enable_o) else $error("bad reset state");
  // A cycle still in reset forces the drivers off, so it starts no override check.
  a_ssp_override: assert property (ssp_en_i && !rst_i |=> port_c_oe_o[5:3] == $past(ssp_oe_i))
    else $error("serial port does not own its pins");
  // The enable copy and the drive request are both one cycle old when the drivers show them.
  a_slave_drive: assert property (parallel_slave_enable_o && $past(host_parallel_port_drive_i) |->
    port_d_oe_o == 8'hff && port_d_out_o == $past(host_parallel_port_wdata_i)) else $error("slave bus not driven");
  a_pullup_off: assert property ((port_b_pullup_o & port_b_oe_o) == 8'h00)
    else $error("pull-up on a driven pin");
  a_dir_write: assert property (reg_wr_i && !rst_i && reg_addr_i == 8'h88 ##1 !parallel_slave_enable_o |=>
    port_d_oe_o == ~$past(reg_wdata_i, 2)) else $error("direction write not applied");
  a_e_bit3: assert property (reg_rd_i && reg_addr_i == 8'h89 |=> !reg_rdata_o[3])
    else $error("unimplemented bit reads one");
  a_host_rdata: assert property (rst_hist_q == 3'h0 |-> host_parallel_port_rdata_o == $past(port_d_in_i, 3))
    else $error("slave read data lags wrongly");
  c_slave: cover property (parallel_slave_enable_o && host_parallel_port_drive_i);
  c_ssp: cover property (ssp_en_i && ssp_oe_i != 3'h0);
  c_e_read: cover property (reg_rd_i && reg_addr_i == 8'h89);
endmodule
bind mpg_gpio_bank mpg_gpio_checker i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .port_b_oe_o(port_b_oe_o), .port_b_pullup_o(port_b_pullup_o), .port_c_oe_o(port_c_oe_o),
  .port_d_in_i(port_d_in_i), .port_d_out_o(port_d_out_o), .port_d_oe_o(port_d_oe_o), .ssp_en_i(ssp_en_i),
  .ssp_oe_i(ssp_oe_i), .host_parallel_port_drive_i(host_parallel_port_drive_i),
  .host_parallel_port_wdata_i(host_parallel_port_wdata_i), .host_parallel_port_rdata_o(host_parallel_port_rdata_o),
  .parallel_slave_enable_o(parallel_slave_enable_o), .port_e_dir_o(port_e_dir_o));
`default_nettype wire

/* mpg_pin_model.sv */
// Pad model of one port: design drive, outside drive, weak pull-up or a wandering float.
`default_nettype none
module mpg_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_oe_i,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pads change every cycle, so a stale level is never taken for data.
  logic [7:0] float_q = 8'h5a;
  always @(posedge clk_i) float_q <= ~float_q;
  // The design's driver wins, then the outside driver, then the pull-up.
  always_comb pin_o = (oe_i & out_i) | (~oe_i & ext_oe_i & ext_i) | (~oe_i & ~ext_oe_i & (pullup_i | float_q));
endmodule
`default_nettype wire

/* test_multi_port_gpio_bank.sv */
// Self-checking bench of the GPIO bank against an integer reference of its registers.
`include "mpg_map.vh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_multi_port_gpio_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, drv = 0, input_buffer_full = 0, output_buffer_full = 0, ovs = 0, pse;
  logic [7:0] addr = 0, wd = 0, hwd = 0, pout = 0, poe = 0, rdata, bo, boe, bpu, co, coe, dq, doe, cin, hrd, opt;
  logic [7:0] bp, cp, dp, sel, eoe, eo, m, ext [3], xen [3];
  logic [23:0] oe3, out3;
  logic [4:0] pen = 0;
  logic [2:0] edir;
  int errors = 0, tests_run = 0, cyc = 0, lat [3], dir [3], v, i, k;
  assign oe3 = {doe, coe, boe};
  assign out3 = {dq, co, bo};
  mpg_gpio_bank i_dut (.ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .port_b_in_i(bp), .port_b_out_o(bo), .port_b_oe_o(boe),
    .port_b_pullup_o(bpu), .port_c_in_i(cp), .port_c_out_o(co), .port_c_oe_o(coe), .port_d_in_i(dp),
    .port_d_out_o(dq), .port_d_oe_o(doe), .sec_osc_en_i(pen[0]), .sec_osc_out_i(pout[0]), .ccp_two_en_i(pen[1]),
    .ccp_two_out_i(pout[1]), .ccp_two_oe_i(poe[1]), .ccp_one_en_i(pen[2]), .ccp_one_out_i(pout[2]),
    .ccp_one_oe_i(poe[2]), .ssp_en_i(pen[3]), .ssp_out_i(pout[5:3]), .ssp_oe_i(poe[5:3]), .usart_en_i(pen[4]),
    .usart_out_i(pout[7:6]), .usart_oe_i(poe[7:6]), .port_c_periph_in_o(cin), .host_parallel_port_drive_i(drv),
    .host_parallel_port_wdata_i(hwd), .input_buffer_full_i(input_buffer_full), .output_buffer_full_i(output_buffer_full),
    .input_overflow_set_i(ovs), .host_parallel_port_rdata_o(hrd), .parallel_slave_enable_o(pse),
    .port_e_dir_o(edir), .timer_pullup_options_o(opt));
  mpg_pin_model i_pb (.clk_i(clk), .out_i(bo), .oe_i(boe), .pullup_i(bpu), .ext_i(ext[0]), .ext_oe_i(xen[0]),
    .pin_o(bp));
  mpg_pin_model i_pc (.clk_i(clk), .out_i(co), .oe_i(coe), .pullup_i(8'h00), .ext_i(ext[1]), .ext_oe_i(xen[1]),
    .pin_o(cp));
  mpg_pin_model i_pd (.clk_i(clk), .out_i(dq), .oe_i(doe), .pullup_i(8'h00), .ext_i(ext[2]), .ext_oe_i(xen[2]),
    .pin_o(dp));
  initial forever #20 clk = ~clk;
  // A hang is cut short well beyond the roughly 150 cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One write cycle; the reference latches and directions follow it.
  task automatic wr8(input int a, input int d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a[7:0];
    wd <= d[7:0];
    @(posedge clk);
    wr <= 1'b0;
    if (a >= 8'h06 && a <= 8'h08) lat[a - 8'h06] = d & 8'hff;
    if (a >= 8'h86 && a <= 8'h88) dir[a - 8'h86] = d & 8'hff;
  endtask
  // One read cycle; the data is looked at in the single cycle where it stands.
  task automatic chkrd(input int a, input int e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a[7:0];
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    for (i = 0; i < 3; i++) begin
      ext[i] = 8'h00;
      xen[i] = 8'h00;
    end
    v = $urandom(6);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values of every control register, then an unmapped hole.
    for (i = 0; i < 3; i++) chkrd(8'h86 + i, 8'hff);
    chkrd(`MPG_ADDR_TIMER_PULLUP_OPTIONS, 8'hff);
    chkrd(`MPG_ADDR_PORT_E_DIR_SLAVE_CTRL, 8'h07);
    chkrd(8'h55, 8'h00);
    // Mixed directions: outputs show the latch, inputs show what the far side drives.
    for (i = 0; i < 3; i++) begin
      k = $urandom;
      ext[i] <= k[7:0];
      wr8(8'h06 + i, $urandom);
      wr8(8'h86 + i, $urandom);
      xen[i] <= dir[i][7:0];
      wt(3);
      `CHK(oe3[i*8 +: 8], ~dir[i] & 8'hff)
      `CHK(out3[i*8 +: 8], lat[i])
      chkrd(8'h06 + i, (lat[i] & ~dir[i] | k & dir[i]) & 8'hff);
    end
    // Weak pull-ups on the second port's inputs only.
    xen[0] <= 8'h00;
    wr8(`MPG_ADDR_TIMER_PULLUP_OPTIONS, 8'h7f);
    wt(3);
    `CHK(bpu, dir[0])
    `CHK(opt, 8'h7f)
    chkrd(8'h06, (lat[0] & ~dir[0] | dir[0]) & 8'hff);
    // Random peripheral enables on the third port against a random direction byte.
    for (k = 0; k < 8; k++) begin
      v = $urandom;
      @(posedge clk);
      pen <= v[4:0];
      pout <= v[15:8];
      poe <= v[23:16];
      wr8(8'h87, v[31:24]);
      sel = {{2{v[4]}}, {3{v[3]}}, v[2], v[1] | v[0], v[0]};
      m = {6'h3f, ~v[0], 1'b1};
      eoe = sel & ((v[23:16] & ~{6'h00, v[0], 1'b0}) | {7'h00, v[0]}) | ~sel & ~v[31:24];
      eo = sel & v[15:8] | ~sel & lat[1][7:0];
      xen[1] <= ~eoe;
      ext[1] <= v[7:0];
      wt(4);
      `CHK(coe, eoe)
      `CHK(co & m, eo & m)
      // Every pin is driven by exactly one side here, so the expected level is known.
      `CHK(cin, eoe & eo | ~eoe & v[7:0])
      // The stored direction byte stays as written while peripherals override it.
      chkrd(8'h87, v[31:24]);
    end
    // Parallel slave mode: the buffer-full bits are read only, the bus takes the host data.
    @(posedge clk);
    pen <= 5'h00;
    input_buffer_full <= 1'b1;
    output_buffer_full <= 1'b1;
    drv <= 1'b1;
    hwd <= v[7:0];
    wr8(`MPG_ADDR_PORT_E_DIR_SLAVE_CTRL, 8'h1d);
    chkrd(`MPG_ADDR_PORT_E_DIR_SLAVE_CTRL, 8'hd5);
    `CHK({pse, edir}, 4'hd)
    `CHK(doe, 8'hff)
    `CHK(dq, v[7:0])
    // Inputs move only on a rising edge, so wait for one before pulsing.
    @(posedge clk);
    ovs <= 1'b1;
    @(posedge clk);
    ovs <= 1'b0;
    chkrd(`MPG_ADDR_PORT_E_DIR_SLAVE_CTRL, 8'hf5);
    @(posedge clk);
    drv <= 1'b0;
    ext[2] <= v[15:8];
    xen[2] <= 8'hff;
    wt(5);
    `CHK(doe, 8'h00)
    `CHK(hrd, v[15:8])
    wr8(`MPG_ADDR_PORT_E_DIR_SLAVE_CTRL, 8'h07);
    wt(3);
    `CHK(pse, 1'b0)
    // Warm reset: directions and options return, the data latches keep their values.
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wt(2);
    `CHK(out3, {lat[2][7:0], lat[1][7:0], lat[0][7:0]})
    `CHK(oe3, 24'h000000)
    `CHK({opt, bpu}, 16'hff00)
    chkrd(8'h87, 8'hff);
    test_done();
  end
endmodule
`default_nettype wire
